// ==== common/fic_regs.svh ====
// Register offsets, field positions, reset values and source bit positions
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH
`define FIC_ADDR_W 8
`define FIC_OFF_QCTRL 8'h28
`define FIC_OFF_QWM 8'h29
`define FIC_OFF_ROUTE1 8'h2a
`define FIC_OFF_ROUTE2 8'h2b
`define FIC_OFF_FILT 8'h2c
`define FIC_OFF_STATUS 8'h0b
`define FIC_OFF_QCOUNT 8'h0c
`define FIC_OFF_IRQ_STAT 8'h30
`define FIC_OFF_IRQ_MASK 8'h31
`define FIC_RST_QCTRL 8'h00
`define FIC_RST_QWM 8'h80
`define FIC_RST_ROUTE 8'h00
`define FIC_RST_FILT 8'h13
`define FIC_QCTRL_MODE_LSB 0
`define FIC_QCTRL_TEMP 2
`define FIC_QCTRL_WM_MSB 3
`define FIC_ROUTE_POL 7
`define FIC_FILT_RANGE_LSB 6
`define FIC_FILT_NARROW 4
`define FIC_FILT_EXT 3
`define FIC_FILT_RATE_LSB 0
`define FIC_SRC_AWAKE 6
`define FIC_SRC_STILL 5
`define FIC_SRC_MOTION 4
`define FIC_SRC_OVERRUN 3
`define FIC_SRC_WATERMARK 2
`define FIC_SRC_QREADY 1
`define FIC_SRC_DREADY 0
`endif

// ==== common/fic_pkg.sv ====
// Types shared by the configuration bank
package fic_pkg;
	typedef enum logic [1:0] {
		FIC_Q_OFF,
		FIC_Q_OLDEST,
		FIC_Q_STREAM,
		FIC_Q_TRIGGER
	} fic_qmode_e;
	typedef enum logic [1:0] {
		FIC_RANGE_2G,
		FIC_RANGE_4G,
		FIC_RANGE_8G
	} fic_range_e;
	typedef enum logic [2:0] {
		FIC_RATE_12P5,
		FIC_RATE_25,
		FIC_RATE_50,
		FIC_RATE_100,
		FIC_RATE_200,
		FIC_RATE_400
	} fic_rate_e;
	typedef logic [6:0] fic_src_t;
endpackage

// ==== common/fic_route_if.sv ====
// Routing configuration and sources to one pin driver
interface fic_route_if;
	logic [7:0] route;
	fic_pkg::fic_src_t src;
	modport bank (output route, output src);
	modport pin (input route, input src);
endinterface

// ==== hdl/fic_irq_pin.sv ====
// One interrupt pin: OR of routed sources, polarity, tristate when unrouted
`include "fic_regs.svh"
module fic_irq_pin (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Configuration
	fic_route_if.pin cfg,
	input wire logic force_off_i,
	// Pin
	output logic pin_o,
	output logic pin_oe_o
);
	logic any;
	assign any = |(cfg.route[6:0] & cfg.src);
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o <= any ^ cfg.route[`FIC_ROUTE_POL];
			pin_oe_o <= (|cfg.route[6:0]) && !force_off_i;
		end
	end
	property p_pin_level;
		@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> pin_o == ($past(any) ^ $past(cfg.route[`FIC_ROUTE_POL]));
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin level wrong");
	property p_pin_hiz;
		@(posedge clock_i) disable iff (!rstn_i)
		(cfg.route[6:0] == 7'h00) |=> !pin_oe_o;
	endproperty
	a_pin_hiz: assert property (p_pin_hiz) else $error("unrouted pin driven");
endmodule

// ==== hdl/fic_wm_cmp.sv ====
// Watermark comparator on the stored entry count
module fic_wm_cmp #(
	parameter int CW = 9
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Compare
	input wire logic [CW-1:0] count_i,
	input wire logic [CW-1:0] level_i,
	input wire logic enable_i,
	output logic hit_o
);
	if (CW < 2) begin
		$error("count width too small");
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hit_o <= 1'b0;
		end else begin
			hit_o <= enable_i && (count_i >= level_i);
		end
	end
	property p_wm;
		@(posedge clock_i) disable iff (!rstn_i)
		(enable_i && count_i >= level_i) |=> hit_o;
	endproperty
	a_wm: assert property (p_wm) else $error("watermark missed");
endmodule

// ==== hdl/fic_bank.sv ====
// Queue, interrupt routing and filter configuration bank
// Behaviour
// - Queue policy: 00 off, 01 oldest kept, 10 stream, 11 triggered.
// - Queue control bit 3 is watermark count MSB, count 0..511.
// - Store-temperature bit adds a temperature word per xyz set.
// - Watermark low byte resets to 0x80.
// - Routing bits 6..0 enable each function onto the pin.
// - Routing bit 7 set makes the pin active low.
// - Several routed functions are ORed onto the pin.
// - Pin with nothing routed is not driven.
// - Route bits: awake, stillness, motion, overrun, watermark, qready, dready.
// - Second routing register has same layout, drives second pin.
// - Status register shows every source regardless of routing.
// - Range field 7:6: 00 2g, 01 4g, 1x 8g.
// - Narrow bandwidth bit: 1 quarter rate, 0 half; resets 1.
// - External trigger bit makes second pin a sampling input.
// - Rate codes 000..100 12.5..200 Hz, 101..111 400 Hz; reset 011.
// - Filter register resets to 0x13.
//
// Implementation choice: the strobed register port.
`include "fic_regs.svh"
module fic_bank #(
	parameter int QDEPTH = 512
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Sensor core events and state
	input wire logic awake_i,
	input wire logic motion_evt_i,
	input wire logic stillness_evt_i,
	input wire logic loop_mode_i,
	input wire logic overrun_i,
	input wire logic qready_i,
	input wire logic dready_i,
	input wire logic [8:0] qcount_i,
	// Configuration to the core
	output fic_pkg::fic_qmode_e qmode_o,
	output logic store_temp_o,
	output fic_pkg::fic_range_e range_o,
	output logic narrow_filter_select_o,
	output logic external_trigger_enable_o,
	output fic_pkg::fic_rate_e sample_rate_select_o,
	output logic ext_trigger_o,
	// Interrupt pins
	output logic irq_pin_first_o,
	output logic irq_pin_first_oe_o,
	input wire logic irq_pin_second_i,
	output logic irq_pin_second_o,
	output logic irq_pin_second_oe_o,
	// Summary interrupt
	output logic irq_o
);
	if (QDEPTH > 512 || QDEPTH < 2) begin
		$error("queue depth unsupported");
	end

	logic [7:0] queue_control;
	logic [7:0] queue_watermark_low;
	logic [7:0] irq_route_first_pin;
	logic [7:0] irq_route_second_pin;
	logic [7:0] filter_and_rate_control;
	logic [6:0] irq_stat;
	logic [6:0] irq_mask;
	logic motion_detect_flag;
	logic stillness_detect_flag;
	logic wm_hit;
	logic [8:0] wm_level;
	fic_pkg::fic_src_t src;
	logic [6:0] src_prev;
	logic [6:0] src_rise;
	logic status_read;

	fic_route_if r1 ();
	fic_route_if r2 ();

	assign wm_level = {queue_control[`FIC_QCTRL_WM_MSB], queue_watermark_low};
	assign status_read = rd_i && (addr_i == `FIC_OFF_STATUS);

	// Register writes
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			queue_control <= `FIC_RST_QCTRL;
			queue_watermark_low <= `FIC_RST_QWM;
			irq_route_first_pin <= `FIC_RST_ROUTE;
			irq_route_second_pin <= `FIC_RST_ROUTE;
			filter_and_rate_control <= `FIC_RST_FILT;
			irq_mask <= 7'h00;
		end else if (wr_i) begin
			if (addr_i == `FIC_OFF_QCTRL) begin
				queue_control <= {4'h0, wdata_i[3:0]};
			end else if (addr_i == `FIC_OFF_QWM) begin
				queue_watermark_low <= wdata_i;
			end else if (addr_i == `FIC_OFF_ROUTE1) begin
				irq_route_first_pin <= wdata_i;
			end else if (addr_i == `FIC_OFF_ROUTE2) begin
				irq_route_second_pin <= wdata_i;
			end else if (addr_i == `FIC_OFF_FILT) begin
				filter_and_rate_control <= wdata_i;
			end else if (addr_i == `FIC_OFF_IRQ_MASK) begin
				irq_mask <= wdata_i[6:0];
			end
		end
	end

	// Motion and stillness held until status read unless loop mode
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			motion_detect_flag <= 1'b0;
		end else if (motion_evt_i) begin
			motion_detect_flag <= 1'b1;
		end else if (status_read || loop_mode_i) begin
			motion_detect_flag <= 1'b0;
		end
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stillness_detect_flag <= 1'b0;
		end else if (stillness_evt_i) begin
			stillness_detect_flag <= 1'b1;
		end else if (status_read || loop_mode_i) begin
			stillness_detect_flag <= 1'b0;
		end
	end

	fic_wm_cmp #(.CW(9)) u_wm (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.count_i(qcount_i),
		.level_i(wm_level),
		.enable_i(queue_control[1:0] != 2'b00),
		.hit_o(wm_hit)
	);

	// Source vector in routing order
	always_comb begin
		src = '0;
		src[`FIC_SRC_AWAKE] = awake_i;
		src[`FIC_SRC_STILL] = stillness_detect_flag;
		src[`FIC_SRC_MOTION] = motion_detect_flag;
		src[`FIC_SRC_OVERRUN] = overrun_i;
		src[`FIC_SRC_WATERMARK] = wm_hit;
		src[`FIC_SRC_QREADY] = qready_i;
		src[`FIC_SRC_DREADY] = dready_i;
	end

	assign r1.route = irq_route_first_pin;
	assign r1.src = src;
	assign r2.route = irq_route_second_pin;
	assign r2.src = src;

	fic_irq_pin u_pin1 (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.cfg(r1),
		.force_off_i(1'b0),
		.pin_o(irq_pin_first_o),
		.pin_oe_o(irq_pin_first_oe_o)
	);
	fic_irq_pin u_pin2 (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.cfg(r2),
		.force_off_i(filter_and_rate_control[`FIC_FILT_EXT]),
		.pin_o(irq_pin_second_o),
		.pin_oe_o(irq_pin_second_oe_o)
	);

	// Sticky interrupt status on rising sources
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			src_prev <= 7'h00;
		end else begin
			src_prev <= src;
		end
	end
	assign src_rise = src & ~src_prev;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat <= 7'h00;
		end else if (wr_i && addr_i == `FIC_OFF_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~wdata_i[6:0]) | src_rise;
		end else begin
			irq_stat <= irq_stat | src_rise;
		end
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// Decoded configuration outputs
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			qmode_o <= fic_pkg::FIC_Q_OFF;
			store_temp_o <= 1'b0;
			range_o <= fic_pkg::FIC_RANGE_2G;
			narrow_filter_select_o <= 1'b1;
			external_trigger_enable_o <= 1'b0;
			sample_rate_select_o <= fic_pkg::FIC_RATE_100;
			ext_trigger_o <= 1'b0;
		end else begin
			qmode_o <= fic_pkg::fic_qmode_e'(queue_control[1:0]);
			store_temp_o <= queue_control[`FIC_QCTRL_TEMP];
			if (filter_and_rate_control[7]) begin
				range_o <= fic_pkg::FIC_RANGE_8G;
			end else if (filter_and_rate_control[6]) begin
				range_o <= fic_pkg::FIC_RANGE_4G;
			end else begin
				range_o <= fic_pkg::FIC_RANGE_2G;
			end
			narrow_filter_select_o <= filter_and_rate_control[`FIC_FILT_NARROW];
			external_trigger_enable_o <= filter_and_rate_control[`FIC_FILT_EXT];
			if (filter_and_rate_control[2:0] > 3'h4) begin
				sample_rate_select_o <= fic_pkg::FIC_RATE_400;
			end else begin
				sample_rate_select_o <= fic_pkg::fic_rate_e'(filter_and_rate_control[2:0]);
			end
			ext_trigger_o <= filter_and_rate_control[`FIC_FILT_EXT] && irq_pin_second_i;
		end
	end

	// Read data one cycle after strobe
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == `FIC_OFF_QCTRL) begin
				rdata_o <= queue_control;
			end else if (addr_i == `FIC_OFF_QWM) begin
				rdata_o <= queue_watermark_low;
			end else if (addr_i == `FIC_OFF_ROUTE1) begin
				rdata_o <= irq_route_first_pin;
			end else if (addr_i == `FIC_OFF_ROUTE2) begin
				rdata_o <= irq_route_second_pin;
			end else if (addr_i == `FIC_OFF_FILT) begin
				rdata_o <= filter_and_rate_control;
			end else if (addr_i == `FIC_OFF_STATUS) begin
				rdata_o <= {1'b0, src};
			end else if (addr_i == `FIC_OFF_QCOUNT) begin
				rdata_o <= qcount_i[7:0];
			end else if (addr_i == `FIC_OFF_IRQ_STAT) begin
				rdata_o <= {1'b0, irq_stat};
			end else if (addr_i == `FIC_OFF_IRQ_MASK) begin
				rdata_o <= {1'b0, irq_mask};
			end else begin
				rdata_o <= 8'h00;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Checks
	property p_motion_hold;
		@(posedge clock_i) disable iff (!rstn_i)
		(motion_detect_flag && !status_read && !loop_mode_i) |=> motion_detect_flag;
	endproperty
	a_motion_hold: assert property (p_motion_hold) else $error("motion dropped");
	property p_status_rd;
		@(posedge clock_i) disable iff (!rstn_i)
		status_read |=> rdata_o[6:0] == $past(src);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read wrong");
	property p_rate;
		@(posedge clock_i) disable iff (!rstn_i)
		(filter_and_rate_control[2:0] >= 3'h5) |=> sample_rate_select_o == fic_pkg::FIC_RATE_400;
	endproperty
	a_rate: assert property (p_rate) else $error("rate decode wrong");
	property p_range;
		@(posedge clock_i) disable iff (!rstn_i)
		filter_and_rate_control[7] |=> range_o == fic_pkg::FIC_RANGE_8G;
	endproperty
	a_range: assert property (p_range) else $error("range decode wrong");
	property p_ext;
		@(posedge clock_i) disable iff (!rstn_i)
		filter_and_rate_control[`FIC_FILT_EXT] |=> !irq_pin_second_oe_o;
	endproperty
	a_ext: assert property (p_ext) else $error("pin2 driven in trigger mode");
	property p_irq;
		@(posedge clock_i) disable iff (!rstn_i)
		(src_rise[0] && irq_mask[0]) |=> ##1 (irq_o || !$past(irq_mask[0]));
	endproperty
	a_irq: assert property (p_irq) else $error("irq missed");
	property p_qmode;
		@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> qmode_o == $past(queue_control[1:0]);
	endproperty
	a_qmode: assert property (p_qmode) else $error("queue mode wrong");
	property p_temp;
		@(posedge clock_i) disable iff (!rstn_i)
		queue_control[2] |=> store_temp_o;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature store wrong");
	property p_still_hold;
		@(posedge clock_i) disable iff (!rstn_i)
		(stillness_detect_flag && !status_read && !loop_mode_i) |=> stillness_detect_flag;
	endproperty
	a_still_hold: assert property (p_still_hold) else $error("stillness dropped");
	property p_narrow;
		@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> narrow_filter_select_o == $past(filter_and_rate_control[`FIC_FILT_NARROW]);
	endproperty
	a_narrow: assert property (p_narrow) else $error("bandwidth select wrong");
	property p_range_4g;
		@(posedge clock_i) disable iff (!rstn_i)
		(filter_and_rate_control[7:6] == 2'b01) |=> range_o == fic_pkg::FIC_RANGE_4G;
	endproperty
	a_range_4g: assert property (p_range_4g) else $error("range 4g decode wrong");
	property p_rate_low;
		@(posedge clock_i) disable iff (!rstn_i)
		(filter_and_rate_control[2:0] <= 3'h4) |=>
			sample_rate_select_o == fic_pkg::fic_rate_e'($past(filter_and_rate_control[2:0]));
	endproperty
	a_rate_low: assert property (p_rate_low) else $error("low rate decode wrong");
	property p_ext_trig;
		@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> ext_trigger_o ==
			($past(filter_and_rate_control[`FIC_FILT_EXT]) && $past(irq_pin_second_i));
	endproperty
	a_ext_trig: assert property (p_ext_trig) else $error("sampling trigger wrong");
	property p_pin1_off;
		@(posedge clock_i) disable iff (!rstn_i)
		(irq_route_first_pin[6:0] == 7'h00) |=> !irq_pin_first_oe_o;
	endproperty
	a_pin1_off: assert property (p_pin1_off) else $error("unrouted pin1 driven");
	property p_pin2_level;
		@(posedge clock_i) disable iff (!rstn_i)
		(irq_route_second_pin[6:0] != 7'h00 && !filter_and_rate_control[`FIC_FILT_EXT]) |=>
			irq_pin_second_oe_o &&
			irq_pin_second_o == ($past(|(irq_route_second_pin[6:0] & src)) ^
			$past(irq_route_second_pin[`FIC_ROUTE_POL]));
	endproperty
	a_pin2_level: assert property (p_pin2_level) else $error("pin2 level wrong");
	property p_stat_set;
		@(posedge clock_i) disable iff (!rstn_i)
		(src_rise != 7'h00) |=> (irq_stat & $past(src_rise)) == $past(src_rise);
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("interrupt status missed");
endmodule

// ==== bench/fic_host_model.sv ====
// Host side of the interrupt pins: line resolution with bus keepers
module fic_host_model (
	// Clock
	input wire logic clock_i,
	// Device pins
	input wire logic pin1_i,
	input wire logic oe1_i,
	input wire logic pin2_i,
	input wire logic oe2_i,
	// Host trigger drive on the second line
	input wire logic trig_en_i,
	input wire logic trig_val_i,
	// Resolved line levels
	output logic line1_o,
	output logic line2_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic keep1 = 1'b0;
	logic keep2 = 1'b1;
	// Keepers hold the last level while nobody drives
	always @(posedge clock_i) begin
		keep1 <= line1_o;
		keep2 <= line2_o;
	end
	assign line1_o = oe1_i ? pin1_i : keep1;
	assign line2_o = oe2_i ? pin2_i : (trig_en_i ? trig_val_i : keep2);
endmodule

// ==== bench/fic_irq_filter_config_tb_top.sv ====
// Self-checking bench of the configuration bank
`include "fic_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module fic_irq_filter_config_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 0, rd_i = 0, awake_i = 0, mot_i = 0, still_i = 0, loop_i = 0;
	logic ovr_i = 0, qrdy_i = 0, drdy_i = 0, trig_en = 0, trig_val = 0;
	logic [8:0] qcount_i = 9'h000;
	logic [7:0] rdata_o;
	fic_pkg::fic_qmode_e qmode_o;
	fic_pkg::fic_range_e range_o;
	fic_pkg::fic_rate_e rate_o;
	logic store_o, narrow_o, ext_en_o, ext_trig_o, p1, p1_oe, p2, p2_oe, irq_o, line1, line2;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [31:0] lfsr = 32'h5c8d;
	logic [7:0] qctrl_m = 8'h00, qwm_m = 8'h80, r1_m = 8'h00, r2_m = 8'h00;
	logic [7:0] filt_m = 8'h13, mask_m = 8'h00, rd_v;
	logic [7:0] rst_tab [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h13};
	logic [6:0] stat_m = 7'h00, prev_m = 7'h00;
	logic mot_f = 0, still_f = 0;
	logic [31:0] r;

	always #12.5 clock_i = ~clock_i;

	fic_bank i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .awake_i(awake_i), .motion_evt_i(mot_i),
		.stillness_evt_i(still_i), .loop_mode_i(loop_i), .overrun_i(ovr_i), .qready_i(qrdy_i),
		.dready_i(drdy_i), .qcount_i(qcount_i), .qmode_o(qmode_o), .store_temp_o(store_o),
		.range_o(range_o), .narrow_filter_select_o(narrow_o),
		.external_trigger_enable_o(ext_en_o), .sample_rate_select_o(rate_o),
		.ext_trigger_o(ext_trig_o), .irq_pin_first_o(p1), .irq_pin_first_oe_o(p1_oe),
		.irq_pin_second_i(line2), .irq_pin_second_o(p2), .irq_pin_second_oe_o(p2_oe),
		.irq_o(irq_o));
	fic_host_model i_host (.clock_i(clock_i), .pin1_i(p1), .oe1_i(p1_oe), .pin2_i(p2),
		.oe2_i(p2_oe), .trig_en_i(trig_en), .trig_val_i(trig_val), .line1_o(line1),
		.line2_o(line2));

	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [6:0] src_now();
		logic wm;
		wm = (qctrl_m[1:0] != 2'b00) && (qcount_i >= {qctrl_m[3], qwm_m});
		return {awake_i, still_f, mot_f, ovr_i, wm, qrdy_i, drdy_i};
	endfunction

	// Settle, then record rising sources as sticky interrupt bits
	task automatic upd();
		repeat (4) @(posedge clock_i);
		#1;
		stat_m |= src_now() & ~prev_m;
		prev_m = src_now();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		case (a)
			`FIC_OFF_QCTRL: qctrl_m = d & 8'h0f;
			`FIC_OFF_QWM: qwm_m = d;
			`FIC_OFF_ROUTE1: r1_m = d;
			`FIC_OFF_ROUTE2: r2_m = d;
			`FIC_OFF_FILT: filt_m = d;
			`FIC_OFF_IRQ_MASK: mask_m = d;
			`FIC_OFF_IRQ_STAT: stat_m &= ~d[6:0];
			default: ;
		endcase
		upd();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		if (a == `FIC_OFF_STATUS) begin
			mot_f = 1'b0;
			still_f = 1'b0;
		end
	endtask

	task automatic pulse(input logic m, input logic s);
		@(posedge clock_i);
		mot_i <= m;
		still_i <= s;
		@(posedge clock_i);
		mot_i <= 1'b0;
		still_i <= 1'b0;
		mot_f |= m;
		still_f |= s;
	endtask

	task automatic chk_pins();
		logic [6:0] s;
		s = src_now();
		`CHK(p1_oe, |r1_m[6:0])
		if (p1_oe === 1'b1) `CHK(line1, (|(r1_m[6:0] & s)) ^ r1_m[7])
		`CHK(p2_oe, (|r2_m[6:0]) & ~filt_m[3])
		if (p2_oe === 1'b1) `CHK(line2, (|(r2_m[6:0] & s)) ^ r2_m[7])
		`CHK(irq_o, |(stat_m & mask_m[6:0]))
	endtask

	task wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clock_i);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge clock_i);
		rstn_i <= 1'b1;
		// Reset values and decoded defaults
		for (int i = 0; i < 5; i++) begin
			rd(8'h28 + 8'(i), rd_v);
			`CHK(rd_v, rst_tab[i])
		end
		`CHK(range_o, 2'd0)
		`CHK(narrow_o, 1'b1)
		`CHK(rate_o, 3'd3)
		`CHK(qmode_o, 2'd0)
		// Every code of the range, rate and queue policy fields
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			wr(`FIC_OFF_FILT, {i[1:0], lfsr[5:3], i[2:0]});
			wr(`FIC_OFF_QCTRL, {lfsr[15:10], i[1:0]});
			`CHK(range_o, i[1] ? 2'd2 : {1'b0, i[0]})
			`CHK(rate_o, (i > 4) ? 3'd5 : i[2:0])
			`CHK(narrow_o, lfsr[4])
			`CHK(ext_en_o, lfsr[3])
			`CHK(qmode_o, i[1:0])
			`CHK(store_o, lfsr[10])
			rd(`FIC_OFF_FILT, rd_v);
			`CHK(rd_v, filt_m)
			rd(`FIC_OFF_QCTRL, rd_v);
			`CHK(rd_v, qctrl_m)
		end
		// Unmapped place
		wr(8'h50, 8'hff);
		rd(8'h50, rd_v);
		`CHK(rd_v, 8'h00)
		wr(`FIC_OFF_FILT, 8'h13);
		// Random routing, sources and interrupt traffic
		for (int i = 0; i < 40; i++) begin
			lfsr = nxt(lfsr);
			r = lfsr;
			wr(`FIC_OFF_ROUTE1, r[7:0]);
			wr(`FIC_OFF_ROUTE2, r[15:8]);
			wr(`FIC_OFF_QCTRL, {4'h0, r[19:16]});
			wr(`FIC_OFF_QWM, r[27:20]);
			lfsr = nxt(lfsr);
			@(posedge clock_i);
			awake_i <= lfsr[0];
			ovr_i <= lfsr[1];
			qrdy_i <= lfsr[2];
			drdy_i <= lfsr[3];
			qcount_i <= lfsr[12:4];
			pulse(lfsr[13], lfsr[14]);
			upd();
			wr(`FIC_OFF_IRQ_MASK, lfsr[31:24]);
			chk_pins();
			rd(`FIC_OFF_STATUS, rd_v);
			`CHK(rd_v[6:0], prev_m)
			upd();
			rd(`FIC_OFF_IRQ_STAT, rd_v);
			`CHK(rd_v[6:0], stat_m)
			wr(`FIC_OFF_IRQ_STAT, lfsr[23:16]);
			chk_pins();
		end
		// Second line as sampling trigger
		wr(`FIC_OFF_ROUTE2, 8'h7f);
		wr(`FIC_OFF_FILT, 8'h1b);
		chk_pins();
		for (int v = 0; v < 2; v++) begin
			@(posedge clock_i);
			trig_en <= 1'b1;
			trig_val <= v[0];
			repeat (3) @(posedge clock_i);
			#1 `CHK(ext_trig_o, v[0])
		end
		// Loop mode clears motion flags without a read
		@(posedge clock_i);
		trig_en <= 1'b0;
		loop_i <= 1'b1;
		pulse(1'b1, 1'b1);
		repeat (4) @(posedge clock_i);
		rd(`FIC_OFF_STATUS, rd_v);
		`CHK(rd_v[5:4], 2'b00)
		wrap_up();
	end
endmodule
